//--- clksw_pkg.sv
// Constants, register map and timing figures for the clock switch and reset sequencer.
// =====================================================================
// How it works
// - After power-up the core runs from the internal 6 MHz oscillator.
// - Internal mode drives the internal clock on the output pin unless disabled.
// - Disabled clock output drives high; disable bit ignored in external mode.
// - Internal mode: input pin is pulled-down aux input bit, never interrupts.
// - Setting external enable halts clocks, stops internal, starts external oscillator.
// - When external clock is stable, clocks restart from it.
// - CPU held extra 128 us (bit 7 low) or 4 ms (bit 7 high).
// - External mode returns to internal only on a supply reset or a suspend wake with external enable clear.
// - Status bit 4 records undervoltage/brown-out reset, bit 6 watchdog reset.
// - Every reset restarts at address zero without pushing anything.
// - Reset clears all registers except processor status.
// - Reset floats general, USB and regulator pins, masks interrupts, stops USB.
// - Undervoltage or brown-out reset selects internal clock, then start-up wait.
// - Watchdog reset keeps clock mode, no settling wait, clears external enable.
// - Reset sets program and data stack pointers to zero.
// - Undervoltage reset on at power-on; start-up wait after supply rises.
// - Undervoltage reset repeats while enabled; firmware disable; off during suspend.
// - Brown-out active whenever undervoltage reset off; both set shared flag.
// - Brown-out trip re-enables undervoltage reset, then threshold and start-up wait.
// - Uncleared watchdog rolls over, resets and sets status bit 6.
// - Watchdog reset lasts about 2 to 4 ms, then restarts at zero.
// - Config bits: 0 ext enable, 1 out disable, 3 UV disable, 7 delay.
package clksw_pkg;

  // =====================================================================
  // CPU I/O port.
  localparam int IO_ADDR_W = 8;
  localparam int IO_DATA_W = 8;
  localparam logic [IO_ADDR_W-1:0] ADDR_WATCHDOG_CLEAR = 8'h26;
  localparam logic [IO_ADDR_W-1:0] ADDR_CLOCK_CONFIG = 8'hF8;
  localparam logic [IO_ADDR_W-1:0] ADDR_PROC_STATUS = 8'hFF;
  localparam logic [IO_DATA_W-1:0] CLOCK_CONFIG_RESET = 8'h00;
  localparam logic [IO_DATA_W-1:0] PROC_STATUS_POWERON = 8'h10;

  // =====================================================================
  // Field positions.
  localparam int CFG_EXT_OSC_EN = 0;
  localparam int CFG_CLK_OUT_DIS = 1;
  localparam int CFG_UV_RESET_DIS = 3;
  localparam int CFG_RESUME_LONG = 7;
  localparam int STAT_UV_BO_FLAG = 4;
  localparam int STAT_WATCHDOG_FLAG = 6;

  // =====================================================================
  // Reset vector and stack pointer start values.
  localparam int PC_W = 13;
  localparam logic [PC_W-1:0] RESET_VECTOR = 13'h0000;
  localparam logic [7:0] STACK_RESET = 8'h00;

  // =====================================================================
  // Timing, with times in their printed units.
  localparam int CLOCK_MHZ = 200;
  localparam int INT_OSC_KHZ = 6000;
  localparam int INT_CLK_HALF = (CLOCK_MHZ * 1000 + INT_OSC_KHZ) / (2 * INT_OSC_KHZ);
  localparam int RESUME_SHORT_US = 128;
  localparam int RESUME_LONG_MS = 4;
  localparam int WAKE_INTERNAL_US = 8;
  localparam int WATCHDOG_RESET_MS = 3;
  localparam int WATCHDOG_TIMEOUT_MS = 8;
  localparam int STARTUP_WAIT_MS = 1;
  localparam int WAIT_W = 24;
  localparam int HALF_W = 6;

  // =====================================================================
  // Sequencer states.
  typedef enum logic [2:0] {
    ST_RESET_HOLD,
    ST_STARTUP,
    ST_RUN,
    ST_SWITCH,
    ST_RESUME,
    ST_WATCHDOG,
    ST_SUSPEND,
    ST_WAKE_INT
  } seq_state_t;

endpackage

//--- clksw_sequencer.sv
// Clock source switch and reset sequencer for the small USB controller core.
`timescale 1ns/1ps
module clksw_sequencer #(
  parameter logic [clksw_pkg::WAIT_W-1:0] STARTUP_WAIT_CYCLES =
    clksw_pkg::WAIT_W'(clksw_pkg::STARTUP_WAIT_MS * 1000 * clksw_pkg::CLOCK_MHZ),
  parameter logic [clksw_pkg::WAIT_W-1:0] RESUME_SHORT_CYCLES =
    clksw_pkg::WAIT_W'(clksw_pkg::RESUME_SHORT_US * clksw_pkg::CLOCK_MHZ),
  parameter logic [clksw_pkg::WAIT_W-1:0] RESUME_LONG_CYCLES =
    clksw_pkg::WAIT_W'(clksw_pkg::RESUME_LONG_MS * 1000 * clksw_pkg::CLOCK_MHZ),
  parameter logic [clksw_pkg::WAIT_W-1:0] WATCHDOG_RESET_CYCLES =
    clksw_pkg::WAIT_W'(clksw_pkg::WATCHDOG_RESET_MS * 1000 * clksw_pkg::CLOCK_MHZ),
  parameter logic [clksw_pkg::WAIT_W-1:0] WATCHDOG_TIMEOUT_CYCLES =
    clksw_pkg::WAIT_W'(clksw_pkg::WATCHDOG_TIMEOUT_MS * 1000 * clksw_pkg::CLOCK_MHZ)
) (
  input wire logic CLOCK_I,
  input wire logic RST_B_I,
  input wire logic [clksw_pkg::IO_ADDR_W-1:0] IO_ADDR_I,
  input wire logic [clksw_pkg::IO_DATA_W-1:0] IO_WDATA_I,
  input wire logic IO_WR_I,
  output logic [clksw_pkg::IO_DATA_W-1:0] IO_RDATA_O,
  input wire logic SUSPEND_I,
  input wire logic WAKE_I,
  input wire logic CLOCK_INPUT_PIN_I,
  input wire logic EXT_CLOCK_STABLE_I,
  input wire logic SUPPLY_ABOVE_THRESHOLD_I,
  input wire logic BROWNOUT_TRIP_I,
  output logic CLOCK_OUTPUT_PIN_O,
  output logic CLOCK_OUTPUT_PIN_OE_B_O,
  output logic CLOCK_INPUT_PULLDOWN_O,
  output logic AUX_INPUT_BIT_O,
  output logic INT_OSC_EN_O,
  output logic EXT_OSC_EN_O,
  output logic EXT_CLOCK_MODE_O,
  output logic CPU_RESET_O,
  output logic CPU_HALT_O,
  output logic [clksw_pkg::PC_W-1:0] PC_START_O,
  output logic [7:0] PROGRAM_STACK_POINTER_START_O,
  output logic [7:0] DATA_STACK_POINTER_START_O,
  output logic REGS_CLEAR_O,
  output logic PINS_HIZ_O,
  output logic INTERRUPTS_DISABLE_O,
  output logic USB_DISABLE_O,
  output logic UNDERVOLTAGE_RESET_EN_O,
  output logic BROWNOUT_RESET_EN_O
);
  import clksw_pkg::*;

  // =====================================================================
  // Pin synchronisers: two flops before any logic reads a pin or detector.
  logic [1:0] sync_xin;
  logic [1:0] sync_stable;
  logic [1:0] sync_supply;
  logic [1:0] sync_bo;

  // Detector inputs come from the analog domain, so they are synchronised too.
  always_ff @(posedge CLOCK_I) begin
    sync_xin <= {sync_xin[0], CLOCK_INPUT_PIN_I};
    sync_stable <= {sync_stable[0], EXT_CLOCK_STABLE_I};
    sync_supply <= {sync_supply[0], SUPPLY_ABOVE_THRESHOLD_I};
    sync_bo <= {sync_bo[0], BROWNOUT_TRIP_I};
  end

  wire xin_s = sync_xin[1];
  wire stable_s = sync_stable[1];
  wire supply_ok_s = sync_supply[1];
  wire bo_s = sync_bo[1];

  // =====================================================================
  // State.
  seq_state_t state;
  seq_state_t next_state;
  logic [IO_DATA_W-1:0] clock_config;
  logic uv_bo_flag;
  logic wd_flag;
  logic ext_mode;
  logic [WAIT_W-1:0] wait_count;
  logic [WAIT_W-1:0] wd_count;
  logic [HALF_W-1:0] int_div;
  logic int_clk;

  // =====================================================================
  // I/O write decode, shared by several processes.
  function automatic logic hit(input logic [IO_ADDR_W-1:0] a, input logic [IO_ADDR_W-1:0] r);
    hit = (a == r);
  endfunction

  wire wr_cfg = IO_WR_I && hit(IO_ADDR_I, ADDR_CLOCK_CONFIG);
  wire wr_stat = IO_WR_I && hit(IO_ADDR_I, ADDR_PROC_STATUS);
  wire wr_wd = IO_WR_I && hit(IO_ADDR_I, ADDR_WATCHDOG_CLEAR);

  // =====================================================================
  // Reset sources.
  // The undervoltage monitor is off when disabled or suspended; brown-out covers the gap.
  wire in_suspend = (state == ST_SUSPEND);
  wire uv_active = !clock_config[CFG_UV_RESET_DIS] && !in_suspend;
  wire bo_active = !uv_active;
  wire uv_trip = uv_active && !supply_ok_s;
  wire bo_trip = bo_active && bo_s;
  wire supply_reset = uv_trip || bo_trip;
  wire wd_rollover = (state == ST_RUN) && (wd_count == WATCHDOG_TIMEOUT_CYCLES);

  // Setting the enable bit from internal mode starts the switch.
  wire start_switch = wr_cfg && IO_WDATA_I[CFG_EXT_OSC_EN] && !ext_mode;
  wire wait_done = (wait_count == '0);

  // =====================================================================
  // Sequencer next state; supply resets outrank everything, then the watchdog.
  always_comb begin
    next_state = state;
    unique case (state)
      ST_RESET_HOLD: begin
        if (supply_ok_s) begin
          next_state = ST_STARTUP;
        end
      end
      ST_STARTUP: begin
        if (wait_done) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (start_switch) begin
          next_state = ST_SWITCH;
        end else if (SUSPEND_I) begin
          next_state = ST_SUSPEND;
        end
      end
      ST_SWITCH: begin
        if (stable_s) begin
          next_state = ST_RESUME;
        end
      end
      ST_RESUME: begin
        if (wait_done) begin
          next_state = ST_RUN;
        end
      end
      ST_WATCHDOG: begin
        if (wait_done) begin
          next_state = ST_RUN;
        end
      end
      ST_SUSPEND: begin
        if (WAKE_I) begin
          next_state = clock_config[CFG_EXT_OSC_EN] ? ST_SWITCH : ST_WAKE_INT;
        end
      end
      ST_WAKE_INT: begin
        if (wait_done) begin
          next_state = ST_RUN;
        end
      end
    endcase
    if (supply_reset) begin
      next_state = ST_RESET_HOLD;
    end else if (wd_rollover) begin
      next_state = ST_WATCHDOG;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RST_B_I) begin
      state <= ST_RESET_HOLD;
    end else begin
      state <= next_state;
    end
  end

  // =====================================================================
  // Wait counter, loaded on entry to a timed state and counted on the active clock.
  wire entering = (next_state != state);
  wire [WAIT_W-1:0] resume_load =
    clock_config[CFG_RESUME_LONG] ? RESUME_LONG_CYCLES : RESUME_SHORT_CYCLES;
  wire [WAIT_W-1:0] wake_int_load = WAIT_W'(WAKE_INTERNAL_US * CLOCK_MHZ);
  wire [WAIT_W-1:0] wait_load =
    (next_state == ST_STARTUP) ? STARTUP_WAIT_CYCLES :
    (next_state == ST_RESUME) ? resume_load :
    (next_state == ST_WATCHDOG) ? WATCHDOG_RESET_CYCLES :
    (next_state == ST_WAKE_INT) ? wake_int_load : '0;

  always_ff @(posedge CLOCK_I) begin
    if (!RST_B_I) begin
      wait_count <= '0;
    end else if (entering) begin
      wait_count <= wait_load;
    end else if (!wait_done) begin
      wait_count <= wait_count - 1'b1;
    end
  end

  // =====================================================================
  // Watchdog timer: runs only while the CPU runs, restarted by any clear write.
  always_ff @(posedge CLOCK_I) begin
    if (!RST_B_I || state != ST_RUN || wr_wd) begin
      wd_count <= '0;
    end else begin
      wd_count <= wd_count + 1'b1;
    end
  end

  // =====================================================================
  // Clock configuration register: any reset source clears it, which also
  // re-enables the undervoltage monitor after a brown-out.
  always_ff @(posedge CLOCK_I) begin
    if (!RST_B_I || supply_reset || wd_rollover) begin
      clock_config <= CLOCK_CONFIG_RESET;
    end else if (wr_cfg) begin
      clock_config <= IO_WDATA_I;
    end
  end

  // =====================================================================
  // Reset cause flags. Firmware clears a flag by writing zero to it; a new
  // reset in the same cycle wins over the clear.
  always_ff @(posedge CLOCK_I) begin
    if (!RST_B_I) begin
      uv_bo_flag <= PROC_STATUS_POWERON[STAT_UV_BO_FLAG];
      wd_flag <= PROC_STATUS_POWERON[STAT_WATCHDOG_FLAG];
    end else begin
      if (supply_reset) begin
        uv_bo_flag <= 1'b1;
      end else if (wr_stat && !IO_WDATA_I[STAT_UV_BO_FLAG]) begin
        uv_bo_flag <= 1'b0;
      end
      if (wd_rollover) begin
        wd_flag <= 1'b1;
      end else if (wr_stat && !IO_WDATA_I[STAT_WATCHDOG_FLAG]) begin
        wd_flag <= 1'b0;
      end
    end
  end

  // Read data is registered; the watchdog clear register is write-only.
  wire [IO_DATA_W-1:0] stat_view =
    IO_DATA_W'({wd_flag, 1'b0, uv_bo_flag}) << STAT_UV_BO_FLAG;
  wire [IO_DATA_W-1:0] next_rdata =
    hit(IO_ADDR_I, ADDR_CLOCK_CONFIG) ? clock_config :
    hit(IO_ADDR_I, ADDR_PROC_STATUS) ? stat_view : '0;

  // =====================================================================
  // Clock mode. A watchdog reset leaves it alone; only supply resets and an
  // internal-mode wake bring the core back to the internal oscillator.
  // The next mode also feeds the registered pin outputs, so they change with the state.
  wire next_ext_mode =
    (next_state == ST_RESET_HOLD || next_state == ST_WAKE_INT) ? 1'b0 :
    (state == ST_SWITCH && next_state == ST_RESUME) ? 1'b1 : ext_mode;

  always_ff @(posedge CLOCK_I) begin
    if (!RST_B_I) begin
      ext_mode <= 1'b0;
    end else begin
      ext_mode <= next_ext_mode;
    end
  end

  // =====================================================================
  // Internal oscillator stand-in: a divider gives about 6 MHz for the pin.
  wire int_running = !ext_mode && (next_state != ST_SWITCH) && (next_state != ST_SUSPEND);
  wire div_end = (int_div == HALF_W'(INT_CLK_HALF - 1));

  always_ff @(posedge CLOCK_I) begin
    if (!RST_B_I || !int_running) begin
      int_div <= '0;
      int_clk <= 1'b0;
    end else if (div_end) begin
      int_div <= '0;
      int_clk <= !int_clk;
    end else begin
      int_div <= int_div + 1'b1;
    end
  end

  // =====================================================================
  // Registered outputs, computed from the next state so they line up with it.
  wire n_reset = (next_state == ST_RESET_HOLD) || (next_state == ST_STARTUP) ||
                 (next_state == ST_WATCHDOG);
  wire n_halt = (next_state != ST_RUN);
  wire n_switching = (next_state == ST_SWITCH) || (next_state == ST_RESUME);
  wire n_ext = next_ext_mode || n_switching;
  wire n_uv_en = !clock_config[CFG_UV_RESET_DIS] && (next_state != ST_SUSPEND);

  // In external mode the pins belong to the resonator, so the output is released.
  wire n_pin_val = clock_config[CFG_CLK_OUT_DIS] ? 1'b1 : int_clk;
  wire n_pin_oe_b = n_ext;

  always_ff @(posedge CLOCK_I) begin
    if (!RST_B_I) begin
      IO_RDATA_O <= '0;
      CLOCK_OUTPUT_PIN_O <= 1'b0;
      CLOCK_OUTPUT_PIN_OE_B_O <= 1'b0;
      CLOCK_INPUT_PULLDOWN_O <= 1'b1;
      AUX_INPUT_BIT_O <= 1'b0;
      INT_OSC_EN_O <= 1'b1;
      EXT_OSC_EN_O <= 1'b0;
      EXT_CLOCK_MODE_O <= 1'b0;
      CPU_RESET_O <= 1'b1;
      CPU_HALT_O <= 1'b1;
      REGS_CLEAR_O <= 1'b1;
      PINS_HIZ_O <= 1'b1;
      INTERRUPTS_DISABLE_O <= 1'b1;
      USB_DISABLE_O <= 1'b1;
      UNDERVOLTAGE_RESET_EN_O <= 1'b1;
      BROWNOUT_RESET_EN_O <= 1'b0;
    end else begin
      IO_RDATA_O <= next_rdata;
      CLOCK_OUTPUT_PIN_O <= n_pin_val;
      CLOCK_OUTPUT_PIN_OE_B_O <= n_pin_oe_b;
      CLOCK_INPUT_PULLDOWN_O <= !n_ext;
      AUX_INPUT_BIT_O <= !n_ext && xin_s;
      INT_OSC_EN_O <= !n_ext && (next_state != ST_SUSPEND);
      EXT_OSC_EN_O <= n_ext && (next_state != ST_SUSPEND);
      EXT_CLOCK_MODE_O <= n_ext;
      CPU_RESET_O <= n_reset;
      CPU_HALT_O <= n_halt;
      REGS_CLEAR_O <= n_reset;
      PINS_HIZ_O <= n_reset;
      INTERRUPTS_DISABLE_O <= n_reset;
      USB_DISABLE_O <= n_reset;
      UNDERVOLTAGE_RESET_EN_O <= n_uv_en;
      BROWNOUT_RESET_EN_O <= !n_uv_en;
    end
  end

  // Start values are constants, loaded by the core whenever CPU_RESET_O is high.
  always_ff @(posedge CLOCK_I) begin
    PC_START_O <= RESET_VECTOR;
    PROGRAM_STACK_POINTER_START_O <= STACK_RESET;
    DATA_STACK_POINTER_START_O <= STACK_RESET;
  end

endmodule

//--- clksw_osc_model.sv
// Behavioural external resonator that drives the clock input pin.
`timescale 1ns/1ps
module clksw_osc_model (
  input wire logic clk_i,
  input wire logic osc_en_i,
  input wire logic slow_i,
  input wire logic gpio_level_i,
  output logic pin_o,
  output logic stable_o
);
  import clksw_pkg::*;
  // ====
  // Start-up times; a crystal rings up far slower than a ceramic part.
  localparam int FAST_START = 20;
  localparam int SLOW_START = 90;
  int age = 0;
  int phase = 0;
  logic wave = 1'b0;
  // Age restarts whenever the oscillator is switched off.
  always @(posedge clk_i) begin
    age <= osc_en_i ? age + 1 : 0;
    phase <= (phase + 1 >= INT_CLK_HALF) ? 0 : phase + 1;
    if (phase + 1 >= INT_CLK_HALF) begin
      wave <= !wave;
    end
  end
  // The 6 MHz wave reaches the input pin only while enabled; the output pin stays open.
  assign pin_o = osc_en_i ? wave : gpio_level_i;
  assign stable_o = osc_en_i && age >= (slow_i ? SLOW_START : FAST_START);
endmodule

//--- clksw_sequencer_asserts.sv
// Port-level checks for the clock switch and reset sequencer.
`timescale 1ns/1ps
module clksw_sequencer_asserts (
  input wire logic CLOCK_I,
  input wire logic RST_B_I,
  input wire logic [clksw_pkg::IO_ADDR_W-1:0] IO_ADDR_I,
  input wire logic [clksw_pkg::IO_DATA_W-1:0] IO_WDATA_I,
  input wire logic IO_WR_I,
  input wire logic CLOCK_OUTPUT_PIN_OE_B_O,
  input wire logic CLOCK_INPUT_PULLDOWN_O,
  input wire logic INT_OSC_EN_O,
  input wire logic EXT_OSC_EN_O,
  input wire logic EXT_CLOCK_MODE_O,
  input wire logic CPU_RESET_O,
  input wire logic CPU_HALT_O,
  input wire logic [clksw_pkg::PC_W-1:0] PC_START_O,
  input wire logic [7:0] PROGRAM_STACK_POINTER_START_O,
  input wire logic [7:0] DATA_STACK_POINTER_START_O,
  input wire logic REGS_CLEAR_O,
  input wire logic PINS_HIZ_O,
  input wire logic INTERRUPTS_DISABLE_O,
  input wire logic USB_DISABLE_O,
  input wire logic UNDERVOLTAGE_RESET_EN_O,
  input wire logic BROWNOUT_RESET_EN_O
);
  import clksw_pkg::*;
  // ====
  // Everything is sampled on the one core clock.
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RST_B_I);
  wire cfg_wr = IO_WR_I && IO_ADDR_I == ADDR_CLOCK_CONFIG;
  // Firmware asks for the external clock while running internally.
  sequence s_cfg_on;
    cfg_wr && IO_WDATA_I[CFG_EXT_OSC_EN] && !CPU_HALT_O && !EXT_CLOCK_MODE_O;
  endsequence
  sequence s_halted;
    EXT_OSC_EN_O && !INT_OSC_EN_O && CPU_HALT_O && EXT_CLOCK_MODE_O;
  endsequence
  a_switch_halts: assert property (s_cfg_on |-> ##2 s_halted)
    else $error("switch did not halt the core");
  a_resume_wait: assert property ($rose(EXT_OSC_EN_O) |-> CPU_HALT_O [*8])
    else $error("core released too early after switch");
  a_ext_sticky: assert property (EXT_CLOCK_MODE_O && !CPU_RESET_O && cfg_wr &&
    !IO_WDATA_I[CFG_EXT_OSC_EN] |=> EXT_CLOCK_MODE_O)
    else $error("external mode left on a config write");
  a_reset_effects: assert property ({REGS_CLEAR_O, PINS_HIZ_O, INTERRUPTS_DISABLE_O,
    USB_DISABLE_O} == {4{CPU_RESET_O}})
    else $error("reset side effects not in step");
  a_start_zero: assert property (PC_START_O == RESET_VECTOR &&
    PROGRAM_STACK_POINTER_START_O == STACK_RESET && DATA_STACK_POINTER_START_O == STACK_RESET)
    else $error("start vector or stack pointer not zero");
  a_reset_halts: assert property (CPU_RESET_O |-> CPU_HALT_O)
    else $error("core runs during reset");
  a_ext_released: assert property (EXT_CLOCK_MODE_O |-> CLOCK_OUTPUT_PIN_OE_B_O)
    else $error("output pin driven in external mode");
  a_int_drives: assert property (INT_OSC_EN_O && !EXT_CLOCK_MODE_O |->
    !CLOCK_OUTPUT_PIN_OE_B_O && CLOCK_INPUT_PULLDOWN_O)
    else $error("internal mode pin setup wrong");
  a_one_osc: assert property (!(INT_OSC_EN_O && EXT_OSC_EN_O))
    else $error("both oscillators enabled");
  a_uv_bo_pair: assert property (BROWNOUT_RESET_EN_O != UNDERVOLTAGE_RESET_EN_O)
    else $error("brown-out not covering undervoltage");
endmodule
bind clksw_sequencer clksw_sequencer_asserts chk (.*);

//--- tb.sv
// Self-checking bench for the clock switch and reset sequencer.
`timescale 1ns/1ps
module tb;
  import clksw_pkg::*;
  // ====
  // Shortened counts keep the run brief; the startup, resume and watchdog expectations derive from them.
  localparam int SW = 40, RS = 30, RL = 60, WR = 25, WT = 600;
  logic clk = 0, rst_b = 0, wr = 0, susp = 0, wake = 0, sup = 0, bo = 0;
  logic slow = 0, gpio = 0, rd_v = 0, last;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, program_stack_pointer, dsp, q[$];
  logic pin, stable, ck_out, oe_b, pd, aux, int_en, ext_en, ext_md, cpu_rst, halt;
  logic clr, hiz, irq_d, usb_d, uv_en, bo_en;
  logic [PC_W-1:0] pc;
  int errors = 0, samples_checked = 0, cycles = 0, n;
  clksw_sequencer #(.STARTUP_WAIT_CYCLES(WAIT_W'(SW)), .RESUME_SHORT_CYCLES(WAIT_W'(RS)),
    .RESUME_LONG_CYCLES(WAIT_W'(RL)), .WATCHDOG_RESET_CYCLES(WAIT_W'(WR)),
    .WATCHDOG_TIMEOUT_CYCLES(WAIT_W'(WT))) uut (
    .CLOCK_I(clk), .RST_B_I(rst_b), .IO_ADDR_I(addr), .IO_WDATA_I(wdata), .IO_WR_I(wr),
    .IO_RDATA_O(rdata), .SUSPEND_I(susp), .WAKE_I(wake), .CLOCK_INPUT_PIN_I(pin),
    .EXT_CLOCK_STABLE_I(stable), .SUPPLY_ABOVE_THRESHOLD_I(sup), .BROWNOUT_TRIP_I(bo),
    .CLOCK_OUTPUT_PIN_O(ck_out), .CLOCK_OUTPUT_PIN_OE_B_O(oe_b), .CLOCK_INPUT_PULLDOWN_O(pd),
    .AUX_INPUT_BIT_O(aux), .INT_OSC_EN_O(int_en), .EXT_OSC_EN_O(ext_en),
    .EXT_CLOCK_MODE_O(ext_md), .CPU_RESET_O(cpu_rst), .CPU_HALT_O(halt), .PC_START_O(pc),
    .PROGRAM_STACK_POINTER_START_O(program_stack_pointer), .DATA_STACK_POINTER_START_O(dsp),
    .REGS_CLEAR_O(clr), .PINS_HIZ_O(hiz), .INTERRUPTS_DISABLE_O(irq_d),
    .USB_DISABLE_O(usb_d), .UNDERVOLTAGE_RESET_EN_O(uv_en), .BROWNOUT_RESET_EN_O(bo_en));
  clksw_osc_model osc (.clk_i(clk), .osc_en_i(ext_en), .slow_i(slow), .gpio_level_i(gpio),
    .pin_o(pin), .stable_o(stable));
  // ====
  // Clock, hang guard and the shared helpers.
  always #2.5 clk = !clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      errors++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic tick(int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  // Writes leave one idle cycle so the strobe never changes twice in a step.
  task automatic write(logic [7:0] a, logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1;
    tick(1);
    wr = 0;
    tick(1);
  endtask
  task automatic pet();
    write(ADDR_WATCHDOG_CLEAR, 8'($urandom));
  endtask
  task automatic read(logic [7:0] a, logic [7:0] e);
    addr = a;
    rd_v = 1;
    q.push_back(e);
    tick(1);
    rd_v = 0;
    tick(1);
  endtask
  // Read data is registered, so it is judged just after the edge that took the address.
  always @(posedge clk) if (rd_v) begin
    #2;
    check("read data", rdata, q.pop_front());
  end
  task automatic wait_for(ref logic s, input logic v, input int lim);
    n = 0;
    while (s !== v && n < lim) begin
      tick(1);
      n++;
    end
    check("wait bound", n < lim, 1);
  endtask
  task automatic toggles(int k);
    n = 0;
    repeat (k) begin
      last = ck_out;
      tick(1);
      if (ck_out !== last) n++;
    end
  endtask
  // ====
  // Main sequence.
  initial begin
    void'($urandom(32'h45c26a9e));
    tick(12);
    check("reset", {cpu_rst, int_en, ext_en, oe_b, uv_en}, 5'b11001);
    rst_b = 1;
    sup = 1;
    wait_for(cpu_rst, 0, SW + 20);
    check("startup", n >= SW, 1);
    check("run", {halt, hiz, clr, irq_d, usb_d, uv_en, bo_en}, 7'b0000010);
    check("start", {pc, program_stack_pointer, dsp}, {RESET_VECTOR, STACK_RESET, STACK_RESET});
    read(ADDR_PROC_STATUS, PROC_STATUS_POWERON);
    read(ADDR_CLOCK_CONFIG, CLOCK_CONFIG_RESET);
    read(ADDR_WATCHDOG_CLEAR, 8'h00);
    read(8'h30, 8'h00);
    $display("test power_on done");
    pet();
    toggles(80);
    check("clock out", n >= 4, 1);
    write(ADDR_CLOCK_CONFIG, 8'h02);
    toggles(60);
    check("out off", {n[7:0], ck_out}, 9'h001);
    repeat (4) begin
      gpio = 1'($urandom);
      tick(4);
      check("aux", {aux, pd}, {gpio, 1'b1});
    end
    $display("test internal_pins done");
    for (int i = 0; i < 2; i++) begin
      slow = 1'(i);
      pet();
      write(ADDR_CLOCK_CONFIG, i ? 8'h81 : 8'h01);
      check("switch", {ext_md, oe_b, int_en}, 3'b110);
      wait_for(halt, 0, 400);
      check("resume", n >= (i ? RL + 90 : RS + 20) && n <= (i ? RL + 102 : RS + 32), 1);
      write(ADDR_CLOCK_CONFIG, 8'h00);
      check("sticky", ext_md, 1);
      // The second pass suspends with the enable set, so the wake goes back to external.
      if (i) write(ADDR_CLOCK_CONFIG, 8'h81);
      susp = 1;
      tick(3);
      check("suspend", {int_en, ext_en, uv_en, bo_en}, 4'b0001);
      susp = 0;
      wake = 1;
      tick(1);
      wake = 0;
      wait_for(halt, 0, 1700);
      check("woken", {ext_md, int_en, uv_en}, i ? 3'b101 : 3'b011);
    end
    $display("test clock_switch done");
    write(ADDR_CLOCK_CONFIG, 8'h01);
    wait_for(halt, 0, 400);
    write(ADDR_PROC_STATUS, 8'h00);
    read(ADDR_PROC_STATUS, 8'h00);
    pet();
    repeat (3) begin
      tick(WT - 40);
      pet();
    end
    wait_for(cpu_rst, 1, WT + 20);
    check("rollover", n >= WT - 5 && n <= WT + 5, 1);
    wait_for(cpu_rst, 0, WR + 10);
    check("wd length", n >= WR && n <= WR + 2, 1);
    check("wd mode", ext_md, 1);
    read(ADDR_PROC_STATUS, 8'h40);
    read(ADDR_CLOCK_CONFIG, 8'h00);
    $display("test watchdog done");
    sup = 0;
    wait_for(cpu_rst, 1, 8);
    check("uv mode", {ext_md, int_en}, 2'b01);
    tick(SW + 10);
    check("held", cpu_rst, 1);
    sup = 1;
    wait_for(cpu_rst, 0, SW + 20);
    check("uv wait", n >= SW, 1);
    read(ADDR_PROC_STATUS, 8'h50);
    write(ADDR_CLOCK_CONFIG, 8'h08);
    tick(1);
    check("uv off", {uv_en, bo_en}, 2'b01);
    bo = 1;
    wait_for(cpu_rst, 1, 8);
    bo = 0;
    wait_for(cpu_rst, 0, SW + 20);
    check("bo wait", {n >= SW, uv_en}, 2'b11);
    read(ADDR_CLOCK_CONFIG, 8'h00);
    $display("test supply done");
    tally_and_finish();
  end
endmodule
